// ==== hw/scfs_top.sv ====
// System clock source switch with crystal fail detection.
`timescale 1ns/1ps
// Overview of operation
// - Select system clock from six sources with a 3-bit selection field.
// - Separate high and low speed crystal fail detectors, each enabled and interrupting.
// - High speed detector enabled forces the internal high speed RC on.
// - Low speed detector enabled forces the internal low speed RC on.
// - High speed crystal stop switches clock to internal RC if crystal-fed.
// - High speed crystal stop sets the high speed fail flag.
// - High speed fail interrupt only while its interrupt enable is set.
// - Stable indication rises when crystal runs again; then software switches back.
module scfs_top
    import scfs_pkg::*;
#(
    parameter int STOP_CNT   = scfs_pkg::STOP_CYCLES,
    parameter int STABLE_CNT = scfs_pkg::STABLE_EDGES
) (
    // Clock, reset and enable.
    input  wire logic                  CLK,
    input  wire logic                  RESET,
    input  wire logic                  CE,
    // Source selection written by software.
    input  wire logic                  SEL_WRITE,
    input  wire logic [SEL_W-1:0]      SEL_WDATA,
    input  wire logic                  PLL_SRC_IS_HS_XTAL,
    // Oscillator enables from software.
    input  wire logic                  HS_XTAL_EN,
    input  wire logic                  LS_XTAL_EN,
    input  wire logic                  HS_RC_EN,
    input  wire logic                  LS_RC_EN,
    // Detector control.
    input  wire logic                  HS_DET_EN,
    input  wire logic                  LS_DET_EN,
    input  wire logic                  HS_FAIL_INT_EN,
    input  wire logic                  LS_FAIL_INT_EN,
    input  wire logic                  HS_FAIL_CLEAR,
    input  wire logic                  LS_FAIL_CLEAR,
    // Crystal activity, one pulse per sampled crystal edge.
    input  wire logic                  HS_XTAL_ACTIVE,
    input  wire logic                  LS_XTAL_ACTIVE,
    // Status and control outputs.
    output logic [SEL_W-1:0]           SYS_CLK_SELECT,
    output logic                       HS_RC_ON,
    output logic                       LS_RC_ON,
    output logic                       HS_FAIL_FLAG,
    output logic                       LS_FAIL_FLAG,
    output logic                       HS_XTAL_STABLE,
    output logic                       LS_XTAL_STABLE,
    output logic                       FAIL_IRQ
);
    logic hs_stop;
    logic ls_stop;
    logic hs_stable;
    logic ls_stable;
    logic hs_on_xtal;
    logic hs_fail_now;
    logic ls_fail_now;

    // True when the selected source is driven by the high speed crystal.
    function automatic logic fed_by_hs(input logic [SEL_W-1:0] sel, input logic pll_hs);
        fed_by_hs = (sel == SRC_HS_XTAL) || (sel == SRC_PLL && pll_hs);
    endfunction

    scfs_detect #(.STOP_CNT(STOP_CNT), .STABLE_CNT(STABLE_CNT), .CW(CNT_W)) u_hs (
        .clk      (CLK),
        .reset    (RESET),
        .ce       (CE),
        .xtal_en  (HS_XTAL_EN),
        .activity (HS_XTAL_ACTIVE),
        .stopped  (hs_stop),
        .stable   (hs_stable)
    );

    scfs_detect #(.STOP_CNT(STOP_CNT), .STABLE_CNT(STABLE_CNT), .CW(CNT_W)) u_ls (
        .clk      (CLK),
        .reset    (RESET),
        .ce       (CE),
        .xtal_en  (LS_XTAL_EN),
        .activity (LS_XTAL_ACTIVE),
        .stopped  (ls_stop),
        .stable   (ls_stable)
    );

    assign hs_on_xtal  = fed_by_hs(SYS_CLK_SELECT, PLL_SRC_IS_HS_XTAL);
    assign hs_fail_now = HS_DET_EN && hs_stop;
    assign ls_fail_now = LS_DET_EN && ls_stop;

    // The fail switch overrides a software write in the same cycle.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            SYS_CLK_SELECT <= SEL_RESET;
        end else if (CE) begin
            if (hs_fail_now && hs_on_xtal) begin
                SYS_CLK_SELECT <= SRC_HS_RC;
            end else if (SEL_WRITE) begin
                SYS_CLK_SELECT <= SEL_WDATA;
            end
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            HS_RC_ON <= 1'b1;
            LS_RC_ON <= 1'b0;
        end else if (CE) begin
            HS_RC_ON <= HS_RC_EN || HS_DET_EN;
            LS_RC_ON <= LS_RC_EN || LS_DET_EN;
        end
    end

    // Set wins over a clear arriving in the same cycle.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            HS_FAIL_FLAG <= 1'b0;
            LS_FAIL_FLAG <= 1'b0;
        end else if (CE) begin
            if (hs_fail_now) begin
                HS_FAIL_FLAG <= 1'b1;
            end else if (HS_FAIL_CLEAR) begin
                HS_FAIL_FLAG <= 1'b0;
            end
            if (ls_fail_now) begin
                LS_FAIL_FLAG <= 1'b1;
            end else if (LS_FAIL_CLEAR) begin
                LS_FAIL_FLAG <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            HS_XTAL_STABLE <= 1'b0;
            LS_XTAL_STABLE <= 1'b0;
        end else if (CE) begin
            HS_XTAL_STABLE <= hs_stable;
            LS_XTAL_STABLE <= ls_stable;
        end
    end

    // Interrupt follows the flags one cycle later, gated by the enables.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            FAIL_IRQ <= 1'b0;
        end else if (CE) begin
            FAIL_IRQ <= (HS_FAIL_FLAG && HS_FAIL_INT_EN)
                     || (LS_FAIL_FLAG && LS_FAIL_INT_EN);
        end
    end
endmodule

// ==== hw/scfs_pkg.sv ====
// Package of constants for the system clock fail switch.
package scfs_pkg;
    localparam int SEL_W = 3;
    // Clock source codes on the select field.
    localparam logic [2:0] SRC_HS_XTAL = 3'h0;
    localparam logic [2:0] SRC_LS_XTAL = 3'h1;
    localparam logic [2:0] SRC_PLL     = 3'h2;
    localparam logic [2:0] SRC_LS_RC   = 3'h3;
    localparam logic [2:0] SRC_HS_RC48 = 3'h4;
    localparam logic [2:0] SRC_HS_RC   = 3'h7;
    localparam logic [2:0] SEL_RESET   = 3'h7;
    localparam int NUM_SOURCES = 6;
    // Stop detector: crystal edges absent this long means stopped.
    localparam int STOP_TIME_NS = 2000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int STOP_CYCLES = STOP_TIME_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    // Stable indication: consecutive edges required after re-enable.
    localparam int STABLE_EDGES = 16;
endpackage

// ==== hw/scfs_detect.sv ====
// Clock-activity detector for one external crystal.
`timescale 1ns/1ps
module scfs_detect #(
    parameter int STOP_CNT   = scfs_pkg::STOP_CYCLES,
    parameter int STABLE_CNT = scfs_pkg::STABLE_EDGES,
    parameter int CW         = scfs_pkg::CNT_W
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic ce,
    input  wire logic xtal_en,
    input  wire logic activity,
    output logic      stopped,
    output logic      stable
);
    import scfs_pkg::*;
    logic [CW-1:0] idle_reg;
    logic [CW-1:0] edges_reg;

    // Counts cycles since the last activity pulse while the crystal is enabled.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            idle_reg <= '0;
        end else if (ce) begin
            if (!xtal_en || activity) begin
                idle_reg <= '0;
            end else if (idle_reg != CW'(STOP_CNT)) begin
                idle_reg <= idle_reg + 1'b1;
            end
        end
    end

    // Counts activity pulses after enable; a stop or disable restarts it.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            edges_reg <= '0;
        end else if (ce) begin
            if (!xtal_en || idle_reg == CW'(STOP_CNT)) begin
                edges_reg <= '0;
            end else if (activity && edges_reg != CW'(STABLE_CNT)) begin
                edges_reg <= edges_reg + 1'b1;
            end
        end
    end

    assign stopped = xtal_en && (idle_reg == CW'(STOP_CNT));
    assign stable  = xtal_en && (edges_reg == CW'(STABLE_CNT));
endmodule

// ==== sim/scfs_xtal_model.sv ====
// Crystal model that pulses activity while enabled and running.
`timescale 1ns/1ps
module scfs_xtal_model (
    input  wire logic clk,
    input  wire logic en,
    input  wire logic run,
    output logic      active
);
    logic ph_reg = 1'b0;
    always_ff @(posedge clk) begin
        ph_reg <= ~ph_reg;
        active <= en && run && ph_reg;
    end
endmodule

// ==== sim/scfs_chk.sv ====
// Port assertions for the fail switch.
`timescale 1ns/1ps
module scfs_chk
    import scfs_pkg::*;
(
    input wire logic CLK, RESET, CE, SEL_WRITE, PLL_SRC_IS_HS_XTAL, HS_DET_EN, LS_DET_EN,
    input wire logic HS_FAIL_INT_EN, LS_FAIL_INT_EN, HS_FAIL_CLEAR, HS_XTAL_ACTIVE,
    input wire logic [SEL_W-1:0] SEL_WDATA, SYS_CLK_SELECT,
    input wire logic HS_RC_ON, LS_RC_ON, HS_FAIL_FLAG, LS_FAIL_FLAG, HS_XTAL_STABLE, FAIL_IRQ
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    sel_load_a: assert property (CE && SEL_WRITE && !HS_DET_EN
        |=> SYS_CLK_SELECT == $past(SEL_WDATA)) else $error("select not loaded");
    hs_rc_a: assert property (CE && HS_DET_EN |=> HS_RC_ON) else $error("hs rc off");
    ls_rc_a: assert property (CE && LS_DET_EN |=> LS_RC_ON) else $error("ls rc off");
    fail_switch_a: assert property ($rose(HS_FAIL_FLAG) && ($past(SYS_CLK_SELECT) == SRC_HS_XTAL
        || $past(SYS_CLK_SELECT) == SRC_PLL && $past(PLL_SRC_IS_HS_XTAL))
        |-> SYS_CLK_SELECT == SRC_HS_RC) else $error("no switch");
    irq_set_a: assert property (CE && HS_FAIL_FLAG && HS_FAIL_INT_EN |=> FAIL_IRQ)
        else $error("irq missing");
    irq_gate_a: assert property (CE && !(HS_FAIL_FLAG && HS_FAIL_INT_EN)
        && !(LS_FAIL_FLAG && LS_FAIL_INT_EN) |=> !FAIL_IRQ) else $error("irq unmasked");
    flag_hold_a: assert property (HS_FAIL_FLAG && !HS_FAIL_CLEAR |=> HS_FAIL_FLAG)
        else $error("flag lost");
    stable_rise_a: assert property ($rose(HS_XTAL_STABLE) |-> $past(HS_XTAL_ACTIVE, 2))
        else $error("stable early");
endmodule
bind scfs_top scfs_chk i_scfs_chk (.*);

// ==== sim/testbench.sv ====
// Self-checking bench for the fail switch.
`timescale 1ns/1ps
module testbench;
    import scfs_pkg::*;
    logic CLK = 1'b0, RESET = 1'b1, CE = 1'b1, SEL_WRITE = 1'b0, PLL_SRC_IS_HS_XTAL = 1'b1;
    logic HS_XTAL_EN = 1'b0, LS_XTAL_EN = 1'b0, HS_RC_EN = 1'b0, LS_RC_EN = 1'b0;
    logic HS_DET_EN = 1'b0, LS_DET_EN = 1'b0, HS_FAIL_INT_EN = 1'b1, LS_FAIL_INT_EN = 1'b1;
    logic HS_FAIL_CLEAR = 1'b0, LS_FAIL_CLEAR = 1'b0, hs_run = 1'b1, ls_run = 1'b1;
    logic [SEL_W-1:0] SEL_WDATA = 3'h0, SYS_CLK_SELECT;
    logic HS_XTAL_ACTIVE, LS_XTAL_ACTIVE, HS_RC_ON, LS_RC_ON, HS_FAIL_FLAG, LS_FAIL_FLAG;
    logic HS_XTAL_STABLE, LS_XTAL_STABLE, FAIL_IRQ;
    logic [2:0] src [6] = '{SRC_HS_XTAL, SRC_LS_XTAL, SRC_PLL, SRC_LS_RC, SRC_HS_RC48, SRC_HS_RC};
    int err_total = 0, comparisons = 0;
    scfs_top #(.STOP_CNT(4), .STABLE_CNT(4)) i_scfs_top (.*);
    scfs_xtal_model i_hs (.clk(CLK), .en(HS_XTAL_EN), .run(hs_run), .active(HS_XTAL_ACTIVE));
    scfs_xtal_model i_ls (.clk(CLK), .en(LS_XTAL_EN), .run(ls_run), .active(LS_XTAL_ACTIVE));
    initial forever #50 CLK = ~CLK;
    task step(input int k);
        repeat (k) @(posedge CLK);
        #10;
    endtask
    task chk(input logic [2:0] g, input logic [2:0] e);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %0t %h %h", $time, g, e);
        end
    endtask
    task chk_b(input logic g, input logic e);
        chk({2'h0, g}, {2'h0, e});
    endtask
    task give_verdict;
        if (err_total == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Waits for the fail flag (0), the stable indication (1) or the slow fail flag (2).
    task await(input int k);
        for (int n = 0; n < 60; n++) begin
            if ((k == 0 ? HS_FAIL_FLAG : k == 1 ? HS_XTAL_STABLE : LS_FAIL_FLAG) === 1'b1) return;
            step(1);
        end
        err_total++;
        give_verdict;
    endtask
    task wsel(input logic [2:0] s);
        SEL_WDATA = s;
        SEL_WRITE = 1'b1;
        step(1);
        SEL_WRITE = 1'b0;
        step(1);
    endtask
    initial begin
        step(20);
        chk(SYS_CLK_SELECT, SEL_RESET);
        RESET = 1'b0;
        for (int i = 0; i < NUM_SOURCES; i++) begin
            wsel(src[i]);
            chk(SYS_CLK_SELECT, src[i]);
        end
        {HS_DET_EN, LS_DET_EN} = 2'h3;
        step(2);
        chk({1'h0, HS_RC_ON, LS_RC_ON}, 3'h3);
        {HS_DET_EN, LS_DET_EN} = 2'h0;
        step(2);
        chk({1'h0, HS_RC_ON, LS_RC_ON}, 3'h0);
        HS_XTAL_EN = 1'b1;
        for (int i = 0; i < 2; i++) begin
            wsel(i == 0 ? SRC_HS_XTAL : SRC_PLL);
            HS_DET_EN = 1'b1;
            step(10);
            chk_b(HS_FAIL_FLAG, 1'b0);
            chk_b(HS_XTAL_STABLE, 1'b1);
            hs_run = 1'b0;
            await(0);
            chk(SYS_CLK_SELECT, SRC_HS_RC);
            step(1);
            chk_b(FAIL_IRQ, 1'b1);
            chk_b(HS_XTAL_STABLE, 1'b0);
            HS_FAIL_INT_EN = 1'b0;
            step(8);
            chk({1'h0, HS_FAIL_FLAG, FAIL_IRQ}, 3'h2);
            {HS_DET_EN, HS_XTAL_EN, HS_FAIL_CLEAR, HS_FAIL_INT_EN} = 4'h3;
            step(1);
            {HS_FAIL_CLEAR, HS_XTAL_EN, hs_run} = 3'h3;
            await(1);
            wsel(SRC_HS_XTAL);
            chk(SYS_CLK_SELECT, SRC_HS_XTAL);
            chk_b(HS_FAIL_FLAG, 1'b0);
        end
        // A PLL fed from elsewhere must keep its selection when the crystal stops.
        PLL_SRC_IS_HS_XTAL = 1'b0;
        wsel(SRC_PLL);
        HS_DET_EN = 1'b1;
        hs_run = 1'b0;
        await(0);
        chk(SYS_CLK_SELECT, SRC_PLL);
        {HS_DET_EN, HS_FAIL_CLEAR, hs_run} = 3'h3;
        step(1);
        HS_FAIL_CLEAR = 1'b0;
        PLL_SRC_IS_HS_XTAL = 1'b1;
        wsel(SRC_HS_XTAL);
        {LS_XTAL_EN, LS_DET_EN} = 2'h3;
        step(10);
        chk_b(LS_XTAL_STABLE, 1'b1);
        ls_run = 1'b0;
        await(2);
        chk(SYS_CLK_SELECT, SRC_HS_XTAL);
        step(1);
        chk_b(FAIL_IRQ, 1'b1);
        {LS_DET_EN, LS_FAIL_CLEAR} = 2'h1;
        step(2);
        chk({1'h0, LS_FAIL_FLAG, FAIL_IRQ}, 3'h0);
        // A reset in mid-run, then a write that a low clock enable must ignore.
        RESET = 1'b1;
        step(1);
        chk(SYS_CLK_SELECT, SEL_RESET);
        chk({1'h0, HS_RC_ON, LS_RC_ON}, 3'h2);
        RESET = 1'b0;
        CE = 1'b0;
        wsel(SRC_LS_RC);
        chk(SYS_CLK_SELECT, SEL_RESET);
        CE = 1'b1;
        wsel(SRC_LS_RC);
        chk(SYS_CLK_SELECT, SRC_LS_RC);
        give_verdict;
    end
endmodule
